//--- core/debug_status_straps.sv
// debug status pins, transaction mirrors and cold-reset boot straps
// Notes on behaviour
// - drive 3-bit trace status code on pins
// - debug boot during reset gives debug exception
// - debug boot is a level, not latched
// - debug boot also sets probe break flag
// - sample test mode select on test clock rise
// - master pin high for cpu, low dma
// - ack mirror low on every data acknowledge
// - start strobe low, block address on 31:4
// - data flag low for data, high fetch
// - debug pins read as mode bits 6:0
// - address line 20 strap: 1 satellite, 0 host
// - host role: cpu writes all config registers
// - satellite role: eeprom loads read-only config
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module debug_status_straps (
  input wire logic clk_i,
  input wire logic rstn_i,
  // core side, same clock
  input wire logic [2:0] trace_code_i,
  input wire logic txn_start_i,
  input wire logic txn_ack_i,
  input wire logic txn_is_cpu_i,
  input wire logic txn_is_data_i,
  input wire logic [27:0] txn_block_addr_i,
  // pins
  input wire logic [2:0] trace_pin_i,
  output logic [2:0] trace_pin_o,
  output logic [2:0] trace_pin_oe_o,
  input wire logic data_flag_n_pin_i,
  output logic data_flag_n_pin_o,
  output logic data_flag_n_pin_oe_o,
  input wire logic ack_mirror_n_pin_i,
  output logic ack_mirror_n_pin_o,
  output logic ack_mirror_n_pin_oe_o,
  input wire logic start_strobe_n_pin_i,
  output logic start_strobe_n_pin_o,
  output logic start_strobe_n_pin_oe_o,
  input wire logic master_cpu_pin_i,
  output logic master_cpu_pin_o,
  output logic master_cpu_pin_oe_o,
  output logic [27:0] block_addr_o,
  output logic block_addr_oe_o,
  input wire logic role_strap_pin_i,
  input wire logic debug_boot_i,
  input wire logic test_clk_i,
  input wire logic test_mode_sel_i,
  // boot results
  output logic boot_exc_o,
  output logic boot_exc_debug_o,
  output logic cfg_write_all_o,
  output logic eeprom_load_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_SETTLE, ST_BOOT, ST_RUN} boot_state_type;

  typedef struct packed {
    boot_state_type st;
    logic [2:0] cnt;
    logic [6:0] mode;
    logic sat;
    logic brk;
    logic exc;
    logic exc_dbg;
    logic eep;
    logic drive;
    logic [2:0] trace;
    logic start_n;
    logic ack_n;
    logic data_n;
    logic master;
    logic [27:0] addr;
    logic addr_oe;
    logic tck_q;
    logic tms_bit;
    logic [7:0] tms_cnt;
    logic [31:0] rdata;
  } top_state_type;

  top_state_type r_r;
  top_state_type r_nxt;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [dbg_strap_pkg::SYN_WIDTH-1:0] syn_raw;
  logic [dbg_strap_pkg::SYN_WIDTH-1:0] syn_lvl;

  assign syn_raw = {test_mode_sel_i, test_clk_i, debug_boot_i, role_strap_pin_i,
                    master_cpu_pin_i, start_strobe_n_pin_i, ack_mirror_n_pin_i,
                    data_flag_n_pin_i, trace_pin_i};

  pin_sync3 #(.W(dbg_strap_pkg::SYN_WIDTH)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(syn_raw),
    .level_o(syn_lvl)
  );

  logic boot_lvl;
  logic tck_rise;
  logic txn_act;
  logic clr_brk;

  assign boot_lvl = syn_lvl[dbg_strap_pkg::SYN_BOOT];
  assign tck_rise = syn_lvl[dbg_strap_pkg::SYN_TCK] & ~r_r.tck_q;
  assign txn_act = txn_start_i | txn_ack_i;
  assign clr_brk = reg_wr_i && (reg_addr_i == dbg_strap_pkg::REG_PROBE_CTRL) &&
                   reg_wdata_i[dbg_strap_pkg::CTRL_BREAK_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.exc = 1'b0;
    r_nxt.eep = 1'b0;
    r_nxt.tck_q = syn_lvl[dbg_strap_pkg::SYN_TCK];
    // boot level is followed live, held beyond the boot decision only by the break flag;
    // only the boot state below and the break flag look at it
    case (r_r.st)
      ST_SETTLE: begin
        // pins stay undriven so the straps can be read
        if (r_r.cnt == dbg_strap_pkg::SETTLE_CYCLES) begin
          r_nxt.mode = syn_lvl[dbg_strap_pkg::MODE_WIDTH-1:0];
          r_nxt.sat = syn_lvl[dbg_strap_pkg::SYN_ROLE];
          r_nxt.st = ST_BOOT;
        end else begin
          r_nxt.cnt = r_r.cnt + 3'h1;
        end
      end
      ST_BOOT: begin
        r_nxt.exc = 1'b1;
        r_nxt.exc_dbg = boot_lvl;
        r_nxt.eep = (r_r.sat == dbg_strap_pkg::ROLE_SATELLITE);
        r_nxt.drive = 1'b1;
        r_nxt.st = ST_RUN;
      end
      ST_RUN: begin
        r_nxt.st = ST_RUN;
      end
      default: begin
        r_nxt.st = ST_SETTLE;
      end
    endcase
    // set wins over the software clear; while the boot level is held high
    // a clear has no lasting effect
    if (boot_lvl) begin
      r_nxt.brk = 1'b1;
    end else if (clr_brk) begin
      r_nxt.brk = 1'b0;
    end
    // transaction mirrors
    r_nxt.trace = trace_code_i;
    r_nxt.start_n = ~txn_start_i;
    r_nxt.ack_n = ~txn_ack_i;
    r_nxt.master = txn_act ? txn_is_cpu_i : 1'b1;
    r_nxt.data_n = txn_act ? ~txn_is_data_i : 1'b1;
    r_nxt.addr_oe = txn_start_i;
    if (txn_start_i) begin
      r_nxt.addr = txn_block_addr_i;
    end
    if (tck_rise) begin
      r_nxt.tms_bit = syn_lvl[dbg_strap_pkg::SYN_TMS];
      r_nxt.tms_cnt = r_r.tms_cnt + 8'h01;
    end
    // register read, answered the next cycle
    r_nxt.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        dbg_strap_pkg::REG_PROBE_CTRL: begin
          r_nxt.rdata[dbg_strap_pkg::CTRL_BREAK_BIT] = r_r.brk;
        end
        dbg_strap_pkg::REG_STRAP_STATUS: begin
          r_nxt.rdata[dbg_strap_pkg::MODE_WIDTH-1:0] = r_r.mode;
          r_nxt.rdata[dbg_strap_pkg::STRAP_ROLE_BIT] = r_r.sat;
          r_nxt.rdata[dbg_strap_pkg::STRAP_DEBUG_BIT] = r_r.exc_dbg;
        end
        dbg_strap_pkg::REG_TMS_STATUS: begin
          r_nxt.rdata[7:0] = r_r.tms_cnt;
          r_nxt.rdata[8] = r_r.tms_bit;
        end
        default: begin
          r_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r <= '{st: ST_SETTLE, cnt: 3'h0, mode: dbg_strap_pkg::MODE_RESET,
               sat: dbg_strap_pkg::ROLE_RESET, brk: 1'b0,
               exc: 1'b0, exc_dbg: 1'b0, eep: 1'b0, drive: 1'b0,
               trace: dbg_strap_pkg::trace_code_debug_run, start_n: 1'b1,
               ack_n: 1'b1, data_n: 1'b1, master: 1'b1, addr: 28'h0,
               addr_oe: 1'b0, tck_q: 1'b0, tms_bit: 1'b0,
               tms_cnt: dbg_strap_pkg::TMS_CNT_RESET, rdata: 32'h0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign trace_pin_o = r_r.trace;
  assign trace_pin_oe_o = {3{r_r.drive}};
  assign data_flag_n_pin_o = r_r.data_n;
  assign data_flag_n_pin_oe_o = r_r.drive;
  assign ack_mirror_n_pin_o = r_r.ack_n;
  assign ack_mirror_n_pin_oe_o = r_r.drive;
  assign start_strobe_n_pin_o = r_r.start_n;
  assign start_strobe_n_pin_oe_o = r_r.drive;
  assign master_cpu_pin_o = r_r.master;
  assign master_cpu_pin_oe_o = r_r.drive;
  assign block_addr_o = r_r.addr;
  // the data bus is only borrowed while the start strobe is shown
  assign block_addr_oe_o = r_r.addr_oe & r_r.drive;
  assign boot_exc_o = r_r.exc;
  assign boot_exc_debug_o = r_r.exc_dbg;
  assign cfg_write_all_o = r_r.drive & (r_r.sat != dbg_strap_pkg::ROLE_SATELLITE);
  assign eeprom_load_o = r_r.eep;
  assign reg_rdata_o = r_r.rdata;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_settle_end;
    r_r.st == ST_SETTLE && r_r.cnt == dbg_strap_pkg::SETTLE_CYCLES;
  endsequence

  sequence seq_boot_pulse;
    boot_exc_o ##1 !boot_exc_o;
  endsequence

  AST_BOOT_SEQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_settle_end |=> ##1 seq_boot_pulse)
    else $error("boot exception not issued after settling");

  AST_BOOT_DEBUG: assert property (@(posedge clk_i) disable iff (!rstn_i)
    r_r.st == ST_BOOT |=> boot_exc_debug_o == $past(boot_lvl))
    else $error("boot exception kind does not follow boot level");

  AST_BREAK_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
    boot_lvl |=> r_r.brk)
    else $error("break flag not set by debug boot");

  AST_TMS_SAMPLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tck_rise |=> r_r.tms_bit == $past(syn_lvl[dbg_strap_pkg::SYN_TMS]) &&
                 r_r.tms_cnt == $past(r_r.tms_cnt) + 8'h01)
    else $error("test mode select not sampled on test clock rise");

  AST_MASTER: assert property (@(posedge clk_i) disable iff (!rstn_i)
    txn_act |=> master_cpu_pin_o == $past(txn_is_cpu_i))
    else $error("master indicator wrong");

  AST_ACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
    txn_ack_i |=> !ack_mirror_n_pin_o)
    else $error("ack mirror not asserted");

  AST_START_ADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    txn_start_i && r_r.drive |=> !start_strobe_n_pin_o && block_addr_oe_o &&
                                 block_addr_o == $past(txn_block_addr_i))
    else $error("start strobe or block address wrong");

  AST_DATA_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
    txn_act |=> data_flag_n_pin_o == !$past(txn_is_data_i))
    else $error("data flag wrong");

  AST_NO_DRIVE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    r_r.st == ST_SETTLE |-> trace_pin_oe_o == 3'h0 && !master_cpu_pin_oe_o)
    else $error("pins driven while straps are read");

  AST_STRAP_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    r_r.st == ST_RUN |=> $stable(r_r.mode) && $stable(r_r.sat))
    else $error("straps changed after capture");

  AST_ROLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    r_r.st == ST_RUN |-> cfg_write_all_o == !r_r.sat)
    else $error("host role config write enable wrong");

  AST_EEPROM: assert property (@(posedge clk_i) disable iff (!rstn_i)
    eeprom_load_o |-> boot_exc_o && r_r.sat)
    else $error("eeprom load outside satellite boot");

endmodule

`default_nettype wire

//--- core/dbg_strap_pkg.sv
// shared constants for the debug status pins and boot straps
package dbg_strap_pkg;

  // ----------------------------------------------------------------
  // trace status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] trace_code_stall = 3'h7;
  localparam logic [2:0] trace_code_jump_with_pc = 3'h6;
  localparam logic [2:0] trace_code_jump_no_pc = 3'h5;
  localparam logic [2:0] trace_code_exception = 3'h4;
  localparam logic [2:0] trace_code_sequential = 3'h3;
  localparam logic [2:0] trace_code_stall_trace = 3'h2;
  localparam logic [2:0] trace_code_trigger = 3'h1;
  localparam logic [2:0] trace_code_debug_run = 3'h0;

  // ----------------------------------------------------------------
  // mode bit positions carried by the debug pins
  // ----------------------------------------------------------------
  localparam int MODE_TRACE_LSB = 0;
  localparam int MODE_DATA_BIT = 3;
  localparam int MODE_ACK_BIT = 4;
  localparam int MODE_START_BIT = 5;
  localparam int MODE_MASTER_BIT = 6;
  localparam int MODE_WIDTH = 7;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYN_ROLE = 7;
  localparam int SYN_BOOT = 8;
  localparam int SYN_TCK = 9;
  localparam int SYN_TMS = 10;
  localparam int SYN_WIDTH = 11;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PROBE_CTRL = 8'h00;
  localparam logic [7:0] REG_STRAP_STATUS = 8'h04;
  localparam logic [7:0] REG_TMS_STATUS = 8'h08;
  localparam int CTRL_BREAK_BIT = 12;
  localparam int STRAP_ROLE_BIT = 7;
  localparam int STRAP_DEBUG_BIT = 8;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] MODE_RESET = 7'h00;
  localparam logic ROLE_SATELLITE = 1'b1;
  localparam logic ROLE_RESET = 1'b0;
  localparam logic [7:0] TMS_CNT_RESET = 8'h00;
  localparam int SYNC_STAGES = 3;
  // cycles after release before the synchronised straps are trusted
  localparam logic [2:0] SETTLE_CYCLES = 3'(SYNC_STAGES + 1);

endpackage

//--- core/pin_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;

endmodule

`default_nettype wire

//--- dv/probe_model.sv
// probe and analyser model: strap resistors, shared pin wires, test clock
`timescale 1ns/1ps
`default_nettype none

module probe_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [6:0] strap_i,
  input wire logic [6:0] dev_o_i,
  input wire logic [6:0] dev_oe_i,
  output logic [6:0] pin_o,
  input wire logic [3:0] n_rises_i,
  input wire logic go_i,
  output logic test_clk_o,
  output logic test_mode_sel_o
);
  logic [3:0] left_r;
  logic [3:0] phase_r;

  // ------------------------------------------------------------
  // pin wires: straps show wherever the device lets go
  // ------------------------------------------------------------
  for (genvar k = 0; k < 7; k++) begin : g_wire
    assign pin_o[k] = dev_oe_i[k] ? dev_o_i[k] : strap_i[k];
  end

  // ------------------------------------------------------------
  // test clock bursts, 10 clk per period, still between bursts
  // ------------------------------------------------------------
  // tms moves on the falling edge so it is steady at every rise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_r <= 4'h0;
      phase_r <= 4'h0;
      test_clk_o <= 1'b0;
      test_mode_sel_o <= 1'b0;
    end else if (go_i) begin
      left_r <= n_rises_i;
      phase_r <= 4'h0;
    end else if (left_r != 4'h0) begin
      phase_r <= (phase_r == 4'h9) ? 4'h0 : phase_r + 4'h1;
      if (phase_r == 4'h0) begin
        test_clk_o <= 1'b1;
      end
      if (phase_r == 4'h5) begin
        test_clk_o <= 1'b0;
        test_mode_sel_o <= ~test_mode_sel_o;
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/debug_status_straps_tb.sv
// self-checking bench for the debug status pins and boot straps
`timescale 1ns/1ps
`default_nettype none

module debug_status_straps_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] trace_code_i = 3'h0;
  logic txn_start_i = 1'b0, txn_ack_i = 1'b0, txn_is_cpu_i = 1'b0, txn_is_data_i = 1'b0;
  logic [27:0] txn_block_addr_i = 28'h0;
  logic role_strap_pin_i = 1'b0, debug_boot_i = 1'b0, go = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [6:0] strap = 7'h00;
  logic [3:0] n_rises = 4'h0;
  logic [6:0] pin, dev_o, dev_oe;
  logic [2:0] trace_o, trace_oe;
  logic data_o, data_oe, ack_o, ack_oe, start_o, start_oe, master_o, master_oe;
  logic [27:0] block_addr_o;
  logic block_addr_oe_o, boot_exc_o, boot_exc_debug_o, cfg_write_all_o, eeprom_load_o;
  logic test_clk, tms;
  logic [31:0] reg_rdata_o, rdat;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  assign dev_o = {master_o, start_o, ack_o, data_o, trace_o};
  assign dev_oe = {master_oe, start_oe, ack_oe, data_oe, trace_oe};

  debug_status_straps i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .trace_code_i(trace_code_i),
    .txn_start_i(txn_start_i), .txn_ack_i(txn_ack_i), .txn_is_cpu_i(txn_is_cpu_i),
    .txn_is_data_i(txn_is_data_i), .txn_block_addr_i(txn_block_addr_i),
    .trace_pin_i(pin[2:0]), .trace_pin_o(trace_o), .trace_pin_oe_o(trace_oe),
    .data_flag_n_pin_i(pin[3]), .data_flag_n_pin_o(data_o), .data_flag_n_pin_oe_o(data_oe),
    .ack_mirror_n_pin_i(pin[4]), .ack_mirror_n_pin_o(ack_o), .ack_mirror_n_pin_oe_o(ack_oe),
    .start_strobe_n_pin_i(pin[5]), .start_strobe_n_pin_o(start_o),
    .start_strobe_n_pin_oe_o(start_oe), .master_cpu_pin_i(pin[6]),
    .master_cpu_pin_o(master_o), .master_cpu_pin_oe_o(master_oe),
    .block_addr_o(block_addr_o), .block_addr_oe_o(block_addr_oe_o),
    .role_strap_pin_i(role_strap_pin_i), .debug_boot_i(debug_boot_i),
    .test_clk_i(test_clk), .test_mode_sel_i(tms), .boot_exc_o(boot_exc_o),
    .boot_exc_debug_o(boot_exc_debug_o), .cfg_write_all_o(cfg_write_all_o),
    .eeprom_load_o(eeprom_load_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  probe_model i_probe (.clk_i(clk_i), .rstn_i(rstn_i), .strap_i(strap), .dev_o_i(dev_o),
    .dev_oe_i(dev_oe), .pin_o(pin), .n_rises_i(n_rises), .go_i(go),
    .test_clk_o(test_clk), .test_mode_sel_o(tms));

  // ------------------------------------------------------------
  // clock, hang guard, verdict
  // ------------------------------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic boot(input logic [6:0] s, input logic role, input logic dbg);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    strap <= s;
    role_strap_pin_i <= role;
    debug_boot_i <= dbg;
    repeat (5) @(posedge clk_i);
    chk(32'h0, {25'h0, dev_oe});
    rstn_i <= 1'b1;
    for (int i = 0; i < 12 && boot_exc_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(32'h1, {31'h0, boot_exc_o});
    chk({31'h0, dbg}, {31'h0, boot_exc_debug_o});
    chk({31'h0, role}, {31'h0, eeprom_load_o});
    chk({31'h0, ~role}, {31'h0, cfg_write_all_o});
    chk(32'h7f, {25'h0, dev_oe});
    @(posedge clk_i);
    role_strap_pin_i <= ~role;
    #1 chk(32'h0, {31'h0, boot_exc_o});
    chk(32'h0, {31'h0, eeprom_load_o});
    rd(8'h04, rdat);
    chk({23'h0, dbg, role, s}, rdat);
  endtask

  task automatic trace_codes;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      trace_code_i <= c[2:0];
      @(posedge clk_i);
      #1 chk(c, {29'h0, pin[2:0]});
    end
  endtask

  task automatic txn_mirror;
    @(posedge clk_i);
    txn_start_i <= 1'b1;
    txn_is_cpu_i <= 1'b1;
    txn_is_data_i <= 1'b0;
    txn_block_addr_i <= 28'hbeef123;
    @(posedge clk_i);
    txn_start_i <= 1'b0;
    txn_ack_i <= 1'b1;
    txn_is_cpu_i <= 1'b0;
    txn_is_data_i <= 1'b1;
    #1 chk(32'hb, {28'h0, pin[6:3]});
    chk({3'h0, 1'b1, 28'hbeef123}, {3'h0, block_addr_oe_o, block_addr_o});
    @(posedge clk_i);
    txn_ack_i <= 1'b0;
    #1 chk(32'h4, {28'h0, pin[6:3]});
    chk(32'h0, {31'h0, block_addr_oe_o});
    @(posedge clk_i);
    #1 chk(32'hf, {28'h0, pin[6:3]});
  endtask

  task automatic break_flag;
    rd(8'h00, rdat);
    chk(32'h1000, rdat);
    wr(8'h00, 32'h1000);
    rd(8'h00, rdat);
    chk(32'h1000, rdat);
    @(posedge clk_i);
    debug_boot_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(8'h00, 32'h1000);
    rd(8'h00, rdat);
    chk(32'h0, rdat);
  endtask

  task automatic tms_sampling;
    @(posedge clk_i);
    n_rises <= 4'h6;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (80) @(posedge clk_i);
    rd(8'h08, rdat);
    chk(32'h106, rdat);
  endtask

  initial begin
    boot(7'h55, 1'b0, 1'b0);
    rd(8'h00, rdat);
    chk(32'h0, rdat);
    trace_codes();
    txn_mirror();
    rd(8'h04, rdat);
    chk(32'h55, rdat);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, rdat);
    chk(32'h0, rdat);
    boot(7'h2a, 1'b1, 1'b1);
    break_flag();
    tms_sampling();
    conclude();
  end
endmodule
`default_nettype wire
